/* shared/lcp_pkg.sv */
// Purpose: shared constants for the character LCD port (host and display ends)
// Assumes: 250 MHz pclk, 4 ns period
// Notes:   least waits round up, longest execution times round down
package lcp_pkg;
    localparam int PERIOD_NS  = 4;
    // host waits, least times in ns
    localparam int T_PWR_NS   = 15_000_000;
    localparam int T_FS1_NS   = 4_100_000;
    localparam int T_FS2_NS   = 100_000;
    localparam int T_FS3_NS   = 5_000_000;
    localparam int T_EXE_NS   = 40_000;
    localparam int T_CLR_NS   = 1_640_000;
    localparam int T_SETUP_NS = 40;
    localparam int T_PULSE_NS = 240;
    localparam int T_HOLD_NS  = 20;
    localparam int PWR_CYC    = (T_PWR_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int FS1_CYC    = (T_FS1_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int FS2_CYC    = (T_FS2_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int FS3_CYC    = (T_FS3_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int WAIT_CYC   = (T_EXE_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int SETUP_CYC  = (T_SETUP_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int PULSE_CYC  = (T_PULSE_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int HOLD_CYC   = (T_HOLD_NS + PERIOD_NS - 1) / PERIOD_NS;
    // display execution times, longest, round down
    localparam int EXE_CYC    = T_EXE_NS / PERIOD_NS;
    localparam int CLR_CYC    = T_CLR_NS / PERIOD_NS;
    localparam int WAIT_W     = 22;
    localparam int BUSY_W     = 20;
    localparam int PH_W       = 8;
    // instruction bytes and bit positions
    localparam logic [7:0] CMD_FUNC     = 8'h38;
    localparam logic [7:0] CMD_DISP_OFF = 8'h08;
    localparam logic [7:0] CMD_DISP_ON  = 8'h0c;
    localparam logic [7:0] CMD_ENTRY    = 8'h06;
    localparam logic [7:0] CHAR_SPACE   = 8'h20;
    localparam int B_CLEAR = 0;
    localparam int B_HOME  = 1;
    localparam int B_ENTRY = 2;
    localparam int B_DISP  = 3;
    localparam int B_SHIFT = 4;
    localparam int B_FUNC  = 5;
    localparam int B_GLYPH_RAM = 6;
    localparam int B_DISPLAY_RAM = 7;
    localparam int F_S     = 0;
    localparam int F_ID    = 1;
    localparam int F_B     = 0;
    localparam int F_C     = 1;
    localparam int F_D     = 2;
    localparam int F_RL    = 2;
    localparam int F_SC    = 3;
    localparam int F_F     = 2;
    localparam int F_N     = 3;
    localparam int F_DL    = 4;
    localparam int BUSY_BIT = 7;
    localparam int INIT_STEPS = 7;
    localparam int DRAM_DEPTH = 80;
    localparam int GLYPH_RAM_DEPTH = 64;
    localparam logic RST_INC   = 1'b1;
    localparam logic RST_WIDE8 = 1'b1;
    // host register map
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RDATA  = 8'h08;
    localparam logic [7:0] REG_CTRL   = 8'h0c;
    localparam int CMD_RS      = 8;
    localparam int CMD_RW      = 9;
    localparam int ST_READY    = 0;
    localparam int ST_PEND     = 1;
    localparam int ST_OWN      = 2;
    localparam int CTRL_REINIT = 0;

    typedef enum logic [2:0] {H_WAIT, H_READY, H_ARB, H_SETUP, H_PULSE, H_HOLD} lcp_hstate_e;
endpackage : lcp_pkg

/* shared/lcp_if.sv */
// Purpose: parallel LCD bus between host logic and the display module
// Assumes: pull-up on the shared data lines when nobody drives
// Notes:   wire level resolved here from the two output enables
`timescale 1ns/1ps
interface lcp_if ();
    logic       instr_or_char_select;
    logic       read_sel;
    logic       strobe;
    logic [7:0] host_data;
    logic       host_oe;
    logic [7:0] lcd_data;
    logic       lcd_oe;
    wire  [7:0] lcd_bus = host_oe ? host_data : (lcd_oe ? lcd_data : 8'hff);

    modport host (
        output instr_or_char_select,
        output read_sel,
        output strobe,
        output host_data,
        output host_oe,
        input  lcd_bus
    );
    modport dev (
        input  instr_or_char_select,
        input  read_sel,
        input  strobe,
        output lcd_data,
        output lcd_oe,
        input  lcd_bus
    );
endinterface : lcp_if

/* hw/lcp_lcd.sv */
// Purpose: display-module end: two registers, address counter, display and glyph RAM
// Assumes: bus sampled synchronously to pclk; strobe falling edge latches writes
// Notes:   writes arriving while busy are dropped, status reads always answer
//
// Functional notes
// - wait 15 ms after power before init
// - wait 4.1 ms after first function set
// - wait 100 us after second function set
// - 5 ms, then function, off, on, entry
// - function set selects two lines, 5x7 font
// - initialise by instructions, not internal reset
// - clear blanks display, cursor to zero
// - home sets address zero, undoes shift
// - entry mode sets step and shift
// - display control: display, cursor, blink bits
// - shift moves cursor or view, RAM kept
// - function set: width, lines, font
// - glyph address set selects glyph RAM
// - display address set selects display RAM
// - status read returns busy and address
// - data write stores into selected RAM
// - data read returns selected RAM byte
// - select line picks instruction or data register
// - host allows each instruction's execution time
// - LCD cycles never overlap memory cycles
`timescale 1ns/1ps
module lcp_lcd #(
    parameter int CLR_CYC = lcp_pkg::CLR_CYC,
    parameter int EXE_CYC = lcp_pkg::EXE_CYC
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    lcp_if.dev              lcd,
    input  wire logic [6:0] view_addr,
    output logic      [7:0] view_char,
    output logic      [6:0] shift_pos,
    output logic            disp_on,
    output logic            cursor_on,
    output logic            blink_on,
    output logic            two_line,
    output logic            font_5x10,
    output logic            bus_width_sel,
    output logic            busy_indicator
);
    localparam int BW = lcp_pkg::BUSY_W;
    localparam int DD = lcp_pkg::DRAM_DEPTH;
    localparam int CG = lcp_pkg::GLYPH_RAM_DEPTH;

    typedef struct packed {
        logic [DD-1:0][7:0] display_ram;
        logic [CG-1:0][7:0] glyph_ram;
        logic [6:0]         ac;
        logic               sel_glyph;
        logic               inc;
        logic               shift_en;
        logic               disp_on;
        logic               cur_on;
        logic               blink;
        logic [6:0]         shift_ofs;
        logic               wide8;
        logic               two_line;
        logic               font;
        logic [BW-1:0]      busy_cnt;
        logic               en_q;
        logic [7:0]         dout;
        logic               doe;
        logic [7:0]         view;
    } lcp_lcd_s;

    lcp_lcd_s s;
    lcp_lcd_s next_s;

    always_comb begin
        logic [7:0] d;
        logic [7:0] rbyte;
        logic [6:0] ac_step;
        logic       fall;
        logic       idle;
        rbyte   = lcp_pkg::CHAR_SPACE;
        d       = lcd.lcd_bus;
        fall    = s.en_q & ~lcd.strobe;
        idle    = (s.busy_cnt == '0);
        ac_step = s.inc ? s.ac + 7'h01 : s.ac - 7'h01;
        if (s.sel_glyph) begin
            rbyte = s.glyph_ram[s.ac[5:0]];
        end else if (s.ac < 7'(DD)) begin
            rbyte = s.display_ram[s.ac];
        end else begin
            rbyte = lcp_pkg::CHAR_SPACE;
        end
        next_s      = s;
        next_s.en_q = lcd.strobe;
        if (!idle) begin
            next_s.busy_cnt = s.busy_cnt - 1'b1;
        end
        // output register one cycle behind the strobe; pulse is far longer
        next_s.doe = lcd.strobe & lcd.read_sel;
        if (lcd.instr_or_char_select) begin
            next_s.dout = rbyte;
        end else begin
            next_s.dout = {~idle, s.ac};
        end
        next_s.view = (view_addr < 7'(DD)) ? s.display_ram[view_addr] : 8'h00;

        if (fall && idle && lcd.read_sel && lcd.instr_or_char_select) begin
            next_s.ac       = ac_step;
            next_s.busy_cnt = BW'(EXE_CYC);
        end else if (fall && idle && !lcd.read_sel) begin
            next_s.busy_cnt = BW'(EXE_CYC);
            if (lcd.instr_or_char_select) begin
                if (s.sel_glyph) begin
                    next_s.glyph_ram[s.ac[5:0]] = d;
                end else if (s.ac < 7'(DD)) begin
                    next_s.display_ram[s.ac] = d;
                end
                next_s.ac = ac_step;
                if (s.shift_en && !s.sel_glyph) begin
                    next_s.shift_ofs = s.inc ? s.shift_ofs + 7'h01 : s.shift_ofs - 7'h01;
                end
            end else if (d[lcp_pkg::B_DISPLAY_RAM]) begin
                next_s.ac        = d[6:0];
                next_s.sel_glyph = 1'b0;
            end else if (d[lcp_pkg::B_GLYPH_RAM]) begin
                next_s.ac        = {1'b0, d[5:0]};
                next_s.sel_glyph = 1'b1;
            end else if (d[lcp_pkg::B_FUNC]) begin
                next_s.wide8    = d[lcp_pkg::F_DL];
                next_s.two_line = d[lcp_pkg::F_N];
                next_s.font     = d[lcp_pkg::F_F];
            end else if (d[lcp_pkg::B_SHIFT]) begin
                // RAM contents untouched either way
                if (d[lcp_pkg::F_SC]) begin
                    next_s.shift_ofs = d[lcp_pkg::F_RL] ? s.shift_ofs - 7'h01
                                                        : s.shift_ofs + 7'h01;
                end else begin
                    next_s.ac = d[lcp_pkg::F_RL] ? s.ac + 7'h01 : s.ac - 7'h01;
                end
            end else if (d[lcp_pkg::B_DISP]) begin
                next_s.disp_on = d[lcp_pkg::F_D];
                next_s.cur_on  = d[lcp_pkg::F_C];
                next_s.blink   = d[lcp_pkg::F_B];
            end else if (d[lcp_pkg::B_ENTRY]) begin
                next_s.inc      = d[lcp_pkg::F_ID];
                next_s.shift_en = d[lcp_pkg::F_S];
            end else if (d[lcp_pkg::B_HOME]) begin
                next_s.ac        = 7'h00;
                next_s.sel_glyph = 1'b0;
                next_s.shift_ofs = 7'h00;
                next_s.busy_cnt  = BW'(CLR_CYC);
            end else if (d[lcp_pkg::B_CLEAR]) begin
                for (int i = 0; i < DD; i++) begin
                    next_s.display_ram[i] = lcp_pkg::CHAR_SPACE;
                end
                next_s.ac        = 7'h00;
                next_s.sel_glyph = 1'b0;
                next_s.shift_ofs = 7'h00;
                next_s.inc       = 1'b1;
                next_s.busy_cnt  = BW'(CLR_CYC);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s       <= '0;
            s.inc   <= lcp_pkg::RST_INC;
            s.wide8 <= lcp_pkg::RST_WIDE8;
        end else begin
            s <= next_s;
        end
    end

    assign lcd.lcd_data   = s.dout;
    assign lcd.lcd_oe     = s.doe;
    assign view_char      = s.view;
    assign shift_pos      = s.shift_ofs;
    assign disp_on        = s.disp_on;
    assign cursor_on      = s.cur_on;
    assign blink_on       = s.blink;
    assign two_line       = s.two_line;
    assign font_5x10      = s.font;
    assign bus_width_sel  = s.wide8;
    assign busy_indicator = (s.busy_cnt != '0);
endmodule : lcp_lcd

/* hw/lcp_host.sv */
// Purpose: host end: power-up init sequencer and APB command port for the LCD
// Assumes: mem_busy high while a memory cycle owns the shared data lines
// Notes:   one command in flight; software polls status for completion
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module lcp_host #(
    parameter int PWR_CYC  = lcp_pkg::PWR_CYC,
    parameter int FS1_CYC  = lcp_pkg::FS1_CYC,
    parameter int FS2_CYC  = lcp_pkg::FS2_CYC,
    parameter int FS3_CYC  = lcp_pkg::FS3_CYC,
    parameter int WAIT_CYC = lcp_pkg::WAIT_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    lcp_if.host              lcd,
    input  wire logic        mem_busy,
    output logic             init_done,
    output logic             lcd_owns_bus
);
    localparam int WW = lcp_pkg::WAIT_W;
    localparam int PW = lcp_pkg::PH_W;

    typedef struct packed {
        lcp_pkg::lcp_hstate_e state;
        logic [WW-1:0]        cnt;
        logic [2:0]           step;
        logic                 ready;
        logic                 polling;
        logic                 pend;
        logic [7:0]           cmd_d;
        logic                 cmd_rs;
        logic                 cmd_rw;
        logic                 rs;
        logic                 rw;
        logic                 en;
        logic [7:0]           dout;
        logic                 doe;
        logic                 own;
        logic [7:0]           rd;
        logic [7:0]           rdata;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
    } lcp_host_s;

    lcp_host_s s;
    lcp_host_s next_s;

    always_comb begin
        next_s         = s;
        next_s.pready  = psel & ~penable;
        next_s.prdata  = 32'h0000_0000;
        next_s.pslverr = 1'b0;
        if (psel && !penable) begin
            case (paddr)
                lcp_pkg::REG_CMD: begin
                    next_s.prdata  = {22'h000000, s.cmd_rw, s.cmd_rs, s.cmd_d};
                    next_s.pslverr = pwrite & (~s.ready | s.pend);
                end
                lcp_pkg::REG_STATUS: next_s.prdata = {29'h0, s.own, s.pend, s.ready};
                lcp_pkg::REG_RDATA:  next_s.prdata = {24'h000000, s.rdata};
                lcp_pkg::REG_CTRL:   next_s.prdata = 32'h0000_0000;
                default:             next_s.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && s.pready && pwrite && !s.pslverr) begin
            if (paddr == lcp_pkg::REG_CMD) begin
                next_s.pend   = 1'b1;
                next_s.cmd_d  = pwdata[7:0];
                next_s.cmd_rs = pwdata[lcp_pkg::CMD_RS];
                next_s.cmd_rw = pwdata[lcp_pkg::CMD_RW];
            end else if (paddr == lcp_pkg::REG_CTRL && pwdata[lcp_pkg::CTRL_REINIT]
                         && s.state == lcp_pkg::H_READY) begin
                // restart whole sequence rather than trust module's own reset
                next_s.ready = 1'b0;
                next_s.step  = 3'h0;
                next_s.cnt   = WW'(PWR_CYC);
                next_s.state = lcp_pkg::H_WAIT;
            end
        end

        case (s.state)
            lcp_pkg::H_WAIT: begin
                if (s.cnt != '0) begin
                    next_s.cnt = s.cnt - 1'b1;
                end else if (s.step == 3'(lcp_pkg::INIT_STEPS)) begin
                    next_s.ready = 1'b1;
                    next_s.state = lcp_pkg::H_READY;
                end else begin
                    next_s.rs    = 1'b0;
                    next_s.rw    = 1'b0;
                    next_s.state = lcp_pkg::H_ARB;
                    case (s.step)
                        3'h4:    next_s.dout = lcp_pkg::CMD_DISP_OFF;
                        3'h5:    next_s.dout = lcp_pkg::CMD_DISP_ON;
                        3'h6:    next_s.dout = lcp_pkg::CMD_ENTRY;
                        default: next_s.dout = lcp_pkg::CMD_FUNC;
                    endcase
                end
            end
            lcp_pkg::H_READY: begin
                if (s.pend) begin
                    next_s.polling = 1'b1;
                    next_s.rs      = 1'b0;
                    next_s.rw      = 1'b1;
                    next_s.state   = lcp_pkg::H_ARB;
                end
            end
            lcp_pkg::H_ARB: begin
                if (!mem_busy) begin
                    next_s.own   = 1'b1;
                    next_s.doe   = ~s.rw;
                    next_s.cnt   = WW'(lcp_pkg::SETUP_CYC - 1);
                    next_s.state = lcp_pkg::H_SETUP;
                end
            end
            lcp_pkg::H_SETUP: begin
                if (s.cnt != '0) begin
                    next_s.cnt = s.cnt - 1'b1;
                end else begin
                    next_s.en    = 1'b1;
                    next_s.cnt   = WW'(lcp_pkg::PULSE_CYC - 1);
                    next_s.state = lcp_pkg::H_PULSE;
                end
            end
            lcp_pkg::H_PULSE: begin
                if (s.cnt != '0) begin
                    next_s.cnt = s.cnt - 1'b1;
                end else begin
                    next_s.en    = 1'b0;
                    next_s.rd    = lcd.lcd_bus;
                    next_s.cnt   = WW'(lcp_pkg::HOLD_CYC - 1);
                    next_s.state = lcp_pkg::H_HOLD;
                end
            end
            lcp_pkg::H_HOLD: begin
                if (s.cnt != '0) begin
                    next_s.cnt = s.cnt - 1'b1;
                end else begin
                    next_s.doe = 1'b0;
                    next_s.own = 1'b0;
                    if (!s.ready) begin
                        next_s.step  = s.step + 3'h1;
                        next_s.state = lcp_pkg::H_WAIT;
                        case (s.step)
                            3'h0:    next_s.cnt = WW'(FS1_CYC);
                            3'h1:    next_s.cnt = WW'(FS2_CYC);
                            3'h2:    next_s.cnt = WW'(FS3_CYC);
                            default: next_s.cnt = WW'(WAIT_CYC);
                        endcase
                    end else if (s.polling) begin
                        next_s.state = lcp_pkg::H_ARB;
                        if (!s.rd[lcp_pkg::BUSY_BIT]) begin
                            next_s.polling = 1'b0;
                            next_s.rs      = s.cmd_rs;
                            next_s.rw      = s.cmd_rw;
                            next_s.dout    = s.cmd_d;
                        end
                    end else begin
                        if (s.rw) begin
                            next_s.rdata = s.rd;
                        end
                        next_s.pend  = 1'b0;
                        next_s.state = lcp_pkg::H_READY;
                    end
                end
            end
            default: next_s.state = lcp_pkg::H_WAIT;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s       <= '0;
            s.state <= lcp_pkg::H_WAIT;
            s.cnt   <= WW'(PWR_CYC);
        end else begin
            s <= next_s;
        end
    end

    assign prdata                   = s.prdata;
    assign pready                   = s.pready;
    assign pslverr                  = s.pslverr;
    assign lcd.instr_or_char_select = s.rs;
    assign lcd.read_sel             = s.rw;
    assign lcd.strobe               = s.en;
    assign lcd.host_data            = s.dout;
    assign lcd.host_oe              = s.doe;
    assign init_done                = s.ready;
    assign lcd_owns_bus             = s.own;
endmodule : lcp_host

/* tb/lcp_chk.sv */
// Purpose: wire checks on the LCD link
// Assumes: one pclk domain
// Notes: init step count restarts only on presetn
`timescale 1ns/1ps
module lcp_chk #(
    // defaults follow the bench's host settings
    parameter int PWR_CYC  = 50,
    parameter int FS1_CYC  = 20,
    parameter int FS2_CYC  = lcp_pkg::FS2_CYC,
    parameter int FS3_CYC  = 20,
    parameter int WAIT_CYC = lcp_pkg::WAIT_CYC
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       instr_or_char_select,
    input wire logic       read_sel,
    input wire logic       strobe,
    input wire logic [7:0] host_data,
    input wire logic       host_oe,
    input wire logic       lcd_oe
);
    localparam logic [7:0] SEQ [7] = '{8'h38, 8'h38, 8'h38, 8'h38, 8'h08, 8'h0c, 8'h06};
    logic [31:0] gap;
    logic [7:0]  hi;
    logic [2:0]  n;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // gap also counts the power wait, strobe is low through reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= '0;
            hi  <= '0;
            n   <= '0;
        end else begin
            gap <= strobe ? '0 : gap + 32'd1;
            hi  <= strobe ? hi + 8'd1 : '0;
            if ($rose(strobe) && n != 3'd7) begin
                n <= n + 3'd1;
            end
        end
    end
    sequence s_init_req;
        $rose(strobe) && n < 3'd7;
    endsequence
    sequence s_status_req;
        $rose(strobe) && read_sel && !instr_or_char_select;
    endsequence
    a_init_bytes: assert property (s_init_req |-> host_data == SEQ[n] && !read_sel)
        else $error("init byte out of order");
    a_init_waits: assert property ($rose(strobe) && n < 3'd7 |->
        gap >= (n == 3'd0 ? PWR_CYC : n == 3'd1 ? FS1_CYC : n == 3'd2 ? FS2_CYC :
                n == 3'd3 ? FS3_CYC : WAIT_CYC))
        else $error("init wait too short");
    a_pulse_width: assert property ($fell(strobe) |-> hi == 8'(lcp_pkg::PULSE_CYC))
        else $error("strobe width wrong");
    a_setup_steady: assert property ($rose(strobe) |->
        $past(instr_or_char_select, 8) == instr_or_char_select && $past(read_sel, 8) == read_sel)
        else $error("select moved before strobe");
    a_write_hold: assert property ($fell(strobe) && !read_sel |->
        (host_oe && $stable(host_data)) [*4])
        else $error("write data released early");
    a_status_drive: assert property (s_status_req |-> ##[1:2] (lcd_oe && !host_oe))
        else $error("status read not answered");
    a_no_clash: assert property (!(host_oe && lcd_oe))
        else $error("both ends drive the bus");
endmodule : lcp_chk

/* tb/lcp_tb.sv */
// Purpose: self-checking bench for both LCD ends
// Assumes: power, first and third waits shortened; init takes about 66k cycles
// Notes: each command is followed by polling pending
`timescale 1ns/1ps
module lcp_tb;
    logic        pclk, presetn, psel, penable, pwrite, mem_busy, pready, pslverr, er;
    logic        init_done, lcd_owns_bus, disp_on, cursor_on, blink_on, two_line, font_5x10;
    logic        bus_width_sel, busy_indicator;
    logic [7:0]  paddr, view_char;
    logic [6:0]  view_addr, shift_pos;
    logic [31:0] pwdata, prdata, rd;
    int          fails, checked, cyc;
    lcp_if i_lcp_if ();
    lcp_host #(.PWR_CYC(50), .FS1_CYC(20), .FS3_CYC(20)) i_lcp_host (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lcd(i_lcp_if), .mem_busy(mem_busy), .init_done(init_done), .lcd_owns_bus(lcd_owns_bus));
    lcp_lcd #(.CLR_CYC(40), .EXE_CYC(20)) i_lcp_lcd (
        .pclk(pclk), .presetn(presetn), .lcd(i_lcp_if), .view_addr(view_addr),
        .view_char(view_char), .shift_pos(shift_pos), .disp_on(disp_on), .cursor_on(cursor_on),
        .blink_on(blink_on), .two_line(two_line), .font_5x10(font_5x10),
        .bus_width_sel(bus_width_sel), .busy_indicator(busy_indicator));
    lcp_chk i_lcp_chk (
        .pclk(pclk), .presetn(presetn), .instr_or_char_select(i_lcp_if.instr_or_char_select),
        .read_sel(i_lcp_if.read_sel), .strobe(i_lcp_if.strobe), .host_data(i_lcp_if.host_data),
        .host_oe(i_lcp_if.host_oe), .lcd_oe(i_lcp_if.lcd_oe));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checked %0d failed %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // software side polls pending, never a fixed wait
    task automatic cmd(input logic rs, input logic rw, input logic [7:0] d);
        apb(1'b1, lcp_pkg::REG_CMD, {22'h0, rw, rs, d});
        chk(er, 1'b0);
        do apb(1'b0, lcp_pkg::REG_STATUS, 32'h0); while (rd[lcp_pkg::ST_PEND] !== 1'b0);
    endtask : cmd
    task automatic stat(input logic [7:0] exp);
        cmd(1'b0, 1'b1, 8'h00);
        apb(1'b0, lcp_pkg::REG_RDATA, 32'h0);
        chk(rd[7:0], exp);
    endtask : stat
    task automatic peek(input logic [6:0] a, input logic [7:0] exp);
        view_addr <= a;
        repeat (3) @(posedge pclk);
        chk(view_char, exp);
    endtask : peek
    task automatic t_early();
        apb(1'b1, lcp_pkg::REG_CMD, 32'h38);
        chk(er, 1'b1);
        apb(1'b0, 8'h10, 32'h0);
        chk(er, 1'b1);
        apb(1'b0, lcp_pkg::REG_CTRL, 32'h0);
        chk(rd, 32'h0);
    endtask : t_early
    task automatic t_init();
        while (init_done !== 1'b1) @(posedge pclk);
        apb(1'b0, lcp_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'h1);
        chk({two_line, font_5x10, bus_width_sel, disp_on, cursor_on, blink_on}, 6'b101100);
    endtask : t_init
    task automatic t_ram();
        cmd(1'b0, 1'b0, 8'h80);
        cmd(1'b1, 1'b0, 8'h41);
        cmd(1'b1, 1'b0, 8'h42);
        peek(7'd0, 8'h41);
        peek(7'd1, 8'h42);
        stat(8'h02);
        cmd(1'b0, 1'b0, 8'h81);
        cmd(1'b1, 1'b1, 8'h00);
        apb(1'b0, lcp_pkg::REG_RDATA, 32'h0);
        chk(rd[7:0], 8'h42);
    endtask : t_ram
    task automatic t_glyph();
        cmd(1'b0, 1'b0, 8'h40);
        cmd(1'b1, 1'b0, 8'h1f);
        cmd(1'b0, 1'b0, 8'h40);
        cmd(1'b1, 1'b1, 8'h00);
        apb(1'b0, lcp_pkg::REG_RDATA, 32'h0);
        chk(rd[7:0], 8'h1f);
        peek(7'd0, 8'h41);
    endtask : t_glyph
    task automatic t_shift();
        cmd(1'b0, 1'b0, 8'h1c);
        chk(shift_pos, 7'h7f);
        cmd(1'b0, 1'b0, 8'h0f);
        chk({disp_on, cursor_on, blink_on}, 3'b111);
        cmd(1'b0, 1'b0, 8'h02);
        chk(shift_pos, 7'h00);
        stat(8'h00);
        peek(7'd0, 8'h41);
    endtask : t_shift
    task automatic t_entry();
        cmd(1'b0, 1'b0, 8'h04);
        cmd(1'b0, 1'b0, 8'h85);
        cmd(1'b1, 1'b0, 8'h55);
        stat(8'h04);
        peek(7'd5, 8'h55);
    endtask : t_entry
    task automatic t_clear();
        cmd(1'b0, 1'b0, 8'h01);
        chk(busy_indicator, 1'b1);
        peek(7'd0, 8'h20);
        stat(8'h00);
    endtask : t_clear
    task automatic t_arb();
        mem_busy <= 1'b1;
        apb(1'b1, lcp_pkg::REG_CMD, 32'h0c);
        repeat (30) @(posedge pclk);
        chk(lcd_owns_bus, 1'b0);
        mem_busy <= 1'b0;
        do apb(1'b0, lcp_pkg::REG_STATUS, 32'h0); while (rd[lcp_pkg::ST_PEND] !== 1'b0);
        chk({cursor_on, blink_on}, 2'b00);
    endtask : t_arb
    initial begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        mem_busy  = 1'b0;
        view_addr = 7'h00;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_early();
        t_init();
        t_ram();
        t_glyph();
        t_shift();
        t_entry();
        t_clear();
        t_arb();
        tally_and_finish();
    end
endmodule : lcp_tb
